// ===== cdu_dac_update.sv
// Register file and update scheduler of the 10-bit current DAC.
// Assumes an 8-bit special register port on sys_clk and timer overflow
// pulses of one cycle from the same clock domain.
`default_nettype none
`include "cdu_params.svh"

module cdu_dac_update
(
   // Clock and reset.
   input  wire logic                    sys_clk,
   input  wire logic                    resetn,
   // Special register port.
   input  wire logic [7:0]              reg_addr,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire logic [7:0]              reg_wdata,
   output logic      [7:0]              reg_rdata,
   // Update events.
   input  wire logic [3:0]              timer_ovf,
   input  wire logic                    ext_convert_strobe,
   // Converter side.
   output logic      [9:0]              dac_code,
   output logic      [1:0]              full_scale_sel,
   output logic      [11:0]             full_scale_ua,
   output logic      [21:0]             out_current_na,
   output logic                         dac_latch_load,
   // Pin control.
   output logic                         dac_enable_bit,
   output logic                         pin_gpio_enable,
   output logic                         pin_analog_connect
);
   import cdu_pkg::*;

   logic [7:0]   ctrl_q, ctrl_d;
   logic [7:0]   high_q, high_d;
   logic [7:0]   low_q, low_d;
   cdu_code_t    code_q, code_d;
   logic         load_q, load_d;
   logic [7:0]   rdata_q, rdata_d;
   logic         rise, fall, event_hit;
   cdu_src_e     src;
   logic [11:0]  fs_ua;

   cdu_strobe_edge cdu_strobe_edge_i
   (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .strobe_pin (ext_convert_strobe),
      .rise_pulse (rise),
      .fall_pulse (fall)
   );

   assign src = cdu_src_e'(ctrl_q[`CDU_SRC_HI:`CDU_SRC_LO]);

   // Qualifying update event for the selected source.
   always_comb
   begin
      case (src)
         CDU_SRC_TIMER0:  event_hit = timer_ovf[0];
         CDU_SRC_TIMER1:  event_hit = timer_ovf[1];
         CDU_SRC_TIMER2:  event_hit = timer_ovf[2];
         CDU_SRC_TIMER3:  event_hit = timer_ovf[3];
         CDU_SRC_RISE:    event_hit = rise;
         CDU_SRC_FALL:    event_hit = fall;
         CDU_SRC_BOTH:    event_hit = rise | fall;
         CDU_SRC_ONWRITE: event_hit = reg_wr &&
                             reg_addr == `CDU_ADDR_DATA_HIGH;
         default:         event_hit = 1'b0;
      endcase
   end

   // Register writes, latch loads and read data.
   always_comb
   begin
      ctrl_d  = ctrl_q;
      high_d  = high_q;
      low_d   = low_q;
      code_d  = code_q;
      load_d  = 1'b0;
      rdata_d = rdata_q;
      if (reg_wr)
      begin
         case (reg_addr)
            `CDU_ADDR_CONTROL:
               ctrl_d = reg_wdata & `CDU_CONTROL_WMASK;
            `CDU_ADDR_DATA_HIGH: high_d = reg_wdata;
            `CDU_ADDR_DATA_LOW:
               low_d  = reg_wdata & `CDU_LOW_WMASK;
            default:             ;
         endcase
      end
      // Data written in the event cycle joins the copy, so it is not lost.
      if (event_hit)
      begin
         code_d = {high_d, low_d[`CDU_LOW_HI:`CDU_LOW_LO]};
         load_d = 1'b1;
      end
      if (reg_rd)
      begin
         case (reg_addr)
            `CDU_ADDR_CONTROL:   rdata_d = ctrl_q;
            `CDU_ADDR_DATA_HIGH: rdata_d = high_q;
            `CDU_ADDR_DATA_LOW:  rdata_d = low_q;
            default:             rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         ctrl_q  <= `CDU_CONTROL_RESET;
         high_q  <= 8'h00;
         low_q   <= 8'h00;
         code_q  <= '0;
         load_q  <= 1'b0;
         rdata_q <= 8'h00;
      end
      else
      begin
         ctrl_q  <= ctrl_d;
         high_q  <= high_d;
         low_q   <= low_d;
         code_q  <= code_d;
         load_q  <= load_d;
         rdata_q <= rdata_d;
      end
   end

   // Full-scale decode in microamps.
   always_comb
   begin
      case (ctrl_q[`CDU_FS_HI:`CDU_FS_LO])
         2'h0:    fs_ua = 12'(`CDU_FS_HALF_UA);
         2'h1:    fs_ua = 12'(`CDU_FS_ONE_UA);
         default: fs_ua = 12'(`CDU_FS_TWO_UA);
      endcase
   end

   // Converter outputs; current in nanoamps is code*fs*1000/1024.
   assign reg_rdata          = rdata_q;
   assign dac_code           = code_q;
   assign dac_latch_load     = load_q;
   assign full_scale_sel     = ctrl_q[`CDU_FS_HI:`CDU_FS_LO];
   assign full_scale_ua      = fs_ua;
   assign out_current_na     = 22'((32'(code_q) * 32'(fs_ua) * 32'd1000)
                                   / 32'(`CDU_FULL_COUNT));
   assign dac_enable_bit     = ctrl_q[`CDU_ENABLE_BIT];
   assign pin_gpio_enable    = ~ctrl_q[`CDU_ENABLE_BIT];
   assign pin_analog_connect = ctrl_q[`CDU_ENABLE_BIT];

   // Rising-strobe mode leaves the code unchanged unless a rising strobe edge occurs.
   property p_hold_strobe;
      @(posedge sys_clk) disable iff (!resetn)
      (src == CDU_SRC_RISE && !rise) |=> $stable(code_q);
   endproperty
   a_hold_strobe: assert property (p_hold_strobe)
      else $error("code changed without rising strobe edge");

   property p_fall_load;
      @(posedge sys_clk) disable iff (!resetn)
      (src == CDU_SRC_FALL && fall) |=> load_q;
   endproperty
   a_fall_load: assert property (p_fall_load)
      else $error("falling edge did not load");

   property p_copy;
      @(posedge sys_clk) disable iff (!resetn)
      (event_hit && !reg_wr) |=>
         code_q == {$past(high_q), $past(low_q[`CDU_LOW_HI:`CDU_LOW_LO])};
   endproperty
   a_copy: assert property (p_copy)
      else $error("latch copy wrong");

   property p_fs;
      @(posedge sys_clk) disable iff (!resetn)
      ctrl_q[`CDU_FS_HI] |-> fs_ua == 12'(`CDU_FS_TWO_UA);
   endproperty
   a_fs: assert property (p_fs)
      else $error("full scale decode wrong");

   property p_low_held;
      @(posedge sys_clk) disable iff (!resetn)
      (src == CDU_SRC_ONWRITE && reg_wr &&
       reg_addr == `CDU_ADDR_DATA_LOW) |=> !load_q;
   endproperty
   a_low_held: assert property (p_low_held)
      else $error("low write updated output");

   property p_timer;
      @(posedge sys_clk) disable iff (!resetn)
      (src == CDU_SRC_TIMER2 && timer_ovf[2]) |=> load_q;
   endproperty
   a_timer: assert property (p_timer)
      else $error("timer overflow did not load");

   property p_pin;
      @(posedge sys_clk) disable iff (!resetn)
      pin_gpio_enable != pin_analog_connect;
   endproperty
   a_pin: assert property (p_pin)
      else $error("pin both gpio and analog");

   property p_unused;
      @(posedge sys_clk) disable iff (!resetn)
      (ctrl_q & ~`CDU_CONTROL_WMASK) == 8'h00 &&
      (low_q & ~`CDU_LOW_WMASK) == 8'h00;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused bits nonzero");

   property p_pulse;
      @(posedge sys_clk) disable iff (!resetn)
      rise |=> !rise;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("edge pulse longer than one cycle");

   property p_current;
      @(posedge sys_clk) disable iff (!resetn)
      code_q == 10'h000 |-> out_current_na == 22'h0;
   endproperty
   a_current: assert property (p_current)
      else $error("zero code gives current");

endmodule : cdu_dac_update

`default_nettype wire

// ===== cdu_params.svh
// Constants for the current DAC update control block.
// Assumes inclusion by the package, design and bench files of this block only.
`ifndef CDU_PARAMS_SVH
`define CDU_PARAMS_SVH

`define CDU_ADDR_CONTROL   8'hB9
`define CDU_ADDR_DATA_HIGH 8'hBA
`define CDU_ADDR_DATA_LOW  8'hBB
`define CDU_CONTROL_RESET  8'h72
`define CDU_CONTROL_WMASK  8'hF3
`define CDU_LOW_WMASK      8'hC0
`define CDU_ENABLE_BIT     7
`define CDU_SRC_HI         6
`define CDU_SRC_LO         4
`define CDU_FS_HI          1
`define CDU_FS_LO          0
`define CDU_LOW_HI         7
`define CDU_LOW_LO         6
`define CDU_CODE_WIDTH     10
`define CDU_FS_HALF_UA     500
`define CDU_FS_ONE_UA      1000
`define CDU_FS_TWO_UA      2000
`define CDU_FULL_COUNT     1024

`endif

// ===== cdu_pkg.sv
// Types shared by the current DAC update control block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "cdu_params.svh"

package cdu_pkg;

   // Update source encodings held in the control register.
   typedef enum logic [2:0]
   {
      CDU_SRC_TIMER0  = 3'h0,
      CDU_SRC_TIMER1  = 3'h1,
      CDU_SRC_TIMER2  = 3'h2,
      CDU_SRC_TIMER3  = 3'h3,
      CDU_SRC_RISE    = 3'h4,
      CDU_SRC_FALL    = 3'h5,
      CDU_SRC_BOTH    = 3'h6,
      CDU_SRC_ONWRITE = 3'h7
   } cdu_src_e;

   typedef logic [`CDU_CODE_WIDTH-1:0] cdu_code_t;

endpackage : cdu_pkg

`default_nettype wire

// ===== cdu_strobe_edge.sv
// Strobe pin synchroniser and edge detector for the current DAC.
// Assumes the strobe pin is asynchronous to sys_clk.
`default_nettype none
`include "cdu_params.svh"

module cdu_strobe_edge
(
   // Clock and reset.
   input  wire logic sys_clk,
   input  wire logic resetn,
   // Raw pin.
   input  wire logic strobe_pin,
   // One-cycle edge pulses.
   output logic      rise_pulse,
   output logic      fall_pulse
);
   import cdu_pkg::*;

   logic meta_q, meta_d;
   logic sync_q, sync_d;
   logic last_q, last_d;

   // Next values; only the second stage and its delayed copy are compared.
   always_comb
   begin
      meta_d = strobe_pin;
      sync_d = meta_q;
      last_d = sync_q;
   end

   // Registers, cleared to low at reset.
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   // Edges from synchronised samples, one cycle each.
   assign rise_pulse = sync_q & ~last_q;
   assign fall_pulse = ~sync_q & last_q;

endmodule : cdu_strobe_edge

`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the current DAC update control block.
// Assumes the package, header and design files are compiled before it.
`default_nettype none
`include "cdu_params.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import cdu_pkg::*;

   logic        sys_clk   = 1'b0;
   logic        resetn    = 1'b0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic        strobe    = 1'b0;
   logic [7:0]  reg_addr  = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic [3:0]  timer_ovf = 4'h0;
   logic [7:0]  reg_rdata;
   cdu_code_t   dac_code;
   cdu_code_t   prev;
   logic [1:0]  full_scale_sel;
   logic [11:0] full_scale_ua;
   logic [21:0] out_current_na;
   logic        dac_latch_load;
   logic        dac_enable_bit;
   logic        pin_gpio_enable;
   logic        pin_analog_connect;
   int          miscompares  = 0;
   int          total_checks = 0;
   int          cycles       = 0;

   // Free-running 125 MHz clock.
   always #4 sys_clk = ~sys_clk;

   cdu_dac_update cdu_dac_update_i (.sys_clk(sys_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_ovf(timer_ovf),
      .ext_convert_strobe(strobe), .dac_code(dac_code),
      .full_scale_sel(full_scale_sel), .full_scale_ua(full_scale_ua),
      .out_current_na(out_current_na), .dac_latch_load(dac_latch_load),
      .dac_enable_bit(dac_enable_bit), .pin_gpio_enable(pin_gpio_enable),
      .pin_analog_connect(pin_analog_connect));

   // Prints the counts and the verdict, then stops the run.
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   // Cuts a hang short; the tests need well under a thousand cycles.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles >= 3000)
      begin
         miscompares++;
         summarize();
      end
   end

   // Compares one observed value against its expectation.
   task automatic chk(input string what, input logic [21:0] seen,
                      input logic [21:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk

   // One register write; returns at the edge that takes it.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // One register read, compared once the registered data has settled.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                     input string what);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk(what, 22'(reg_rdata), 22'(exp));
      @(posedge sys_clk);
   endtask : rd

   // Waits a bounded time for one load pulse and checks the new code.
   task automatic wait_load(input cdu_code_t exp, input string what);
      int n;
      n = 0;
      @(negedge sys_clk);
      while (dac_latch_load !== 1'b1 && n < 6)
      begin
         @(negedge sys_clk);
         n++;
      end
      chk({what, " load"}, 22'(dac_latch_load), 22'h1);
      chk({what, " code"}, 22'(dac_code), 22'(exp));
      @(negedge sys_clk);
      chk({what, " pulse"}, 22'(dac_latch_load), 22'h0);
      prev = exp;
      @(posedge sys_clk);
   endtask : wait_load

   // Checks that no load happens and the code holds for n cycles.
   task automatic hold(input int n, input string what);
      repeat (n)
      begin
         @(negedge sys_clk);
         chk({what, " load"}, 22'(dac_latch_load), 22'h0);
         chk({what, " code"}, 22'(dac_code), 22'(prev));
      end
      @(posedge sys_clk);
   endtask : hold

   // Reset values of the control register and the outputs.
   task automatic t_reset;
      @(negedge sys_clk);
      chk("fs ua", 22'(full_scale_ua), 22'h7D0);
      chk("gpio", 22'(pin_gpio_enable), 22'h1);
      chk("enable", 22'(dac_enable_bit), 22'h0);
      chk("analog", 22'(pin_analog_connect), 22'h0);
      @(posedge sys_clk);
      rd(`CDU_ADDR_CONTROL, 8'h72, "control");
      prev = 10'h000;
   endtask : t_reset

   // Write-through mode, masks and the pin hand-over.
   task automatic t_ondemand;
      wr(`CDU_ADDR_DATA_LOW, 8'hFF);
      hold(3, "low held");
      rd(`CDU_ADDR_DATA_LOW, 8'hC0, "low mask");
      wr(`CDU_ADDR_DATA_HIGH, 8'hA5);
      wait_load(10'h297, "high write");
      wr(`CDU_ADDR_CONTROL, 8'hFF);
      rd(`CDU_ADDR_CONTROL, 8'hF3, "ctl mask");
      chk("gpio", 22'(pin_gpio_enable), 22'h0);
      chk("analog", 22'(pin_analog_connect), 22'h1);
      chk("enable", 22'(dac_enable_bit), 22'h1);
      wr(`CDU_ADDR_CONTROL, 8'h70);
      // Let an edge pass so the control write has reached the pins before the check.
      @(posedge sys_clk);
      chk("gpio back", 22'(pin_gpio_enable), 22'h1);
   endtask : t_ondemand

   // Full-scale selections and current at the top code and at one LSB.
   task automatic t_scale;
      longint ua;
      wr(`CDU_ADDR_DATA_HIGH, 8'hFF);
      wait_load(10'h3FF, "top code");
      for (int fs = 0; fs < 4; fs++)
      begin
         wr(`CDU_ADDR_CONTROL, {6'h1C, 2'(fs)});
         ua = (fs == 0) ? 500 : (fs == 1) ? 1000 : 2000;
         @(negedge sys_clk);
         chk("fs sel", 22'(full_scale_sel), 22'(fs));
         chk("fs ua", 22'(full_scale_ua), 22'(ua));
         chk("current", out_current_na, 22'(1023 * ua * 1000 / 1024));
         @(posedge sys_clk);
      end
      wr(`CDU_ADDR_DATA_LOW, 8'h40);
      @(posedge sys_clk);
      wr(`CDU_ADDR_DATA_HIGH, 8'h00);
      wait_load(10'h001, "one lsb");
      chk("current", out_current_na, 22'(2000 * 1000 / 1024));
   endtask : t_scale

   // Each timer source ignores the next timer's overflow and loads on its own.
   task automatic t_timers;
      for (int k = 0; k < 4; k++)
      begin
         wr(`CDU_ADDR_CONTROL, {1'b0, 3'(k), 4'h2});
         @(posedge sys_clk);
         wr(`CDU_ADDR_DATA_HIGH, 8'(8'h10 + k));
         hold(3, "timer held");
         timer_ovf <= 4'(4'h1 << ((k + 1) % 4));
         @(posedge sys_clk);
         timer_ovf <= 4'h0;
         hold(3, "other timer");
         timer_ovf <= 4'(4'h1 << k);
         @(posedge sys_clk);
         timer_ovf <= 4'h0;
         wait_load({8'(8'h10 + k), 2'h1}, "timer");
      end
   endtask : t_timers

   // Rising, falling and both-edge strobe modes.
   task automatic t_strobe;
      for (int m = 4; m < 7; m++)
      begin
         wr(`CDU_ADDR_CONTROL, {1'b0, 3'(m), 4'h2});
         @(posedge sys_clk);
         wr(`CDU_ADDR_DATA_HIGH, 8'(8'h20 + m));
         hold(6, "strobe held");
         strobe <= 1'b1;
         @(posedge sys_clk);
         if (m == 5)
            hold(8, "rise ignored");
         else
            wait_load({8'(8'h20 + m), 2'h1}, "rise");
         strobe <= 1'b0;
         @(posedge sys_clk);
         if (m == 4)
            hold(8, "fall ignored");
         else
            wait_load({8'(8'h20 + m), 2'h1}, "fall");
      end
   endtask : t_strobe

   // Reset, then the scenarios in turn.
   initial
   begin
      prev = 10'h000;
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_ondemand();
      t_scale();
      t_timers();
      t_strobe();
      summarize();
   end
endmodule : testbench

`default_nettype wire
